// ==== swr_sleep_wake_ctrl.sv ====
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module swr_sleep_wake_ctrl
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire swr_pkg::swr_bus_t bus,
	output logic [15:0] rdata,
	input wire swr_pkg::swr_wake_t wake,
	input wire logic usb_bus_reset,
	input wire logic boost_ok,
	input wire logic [31:0] gpio_dir_in,
	input wire logic [31:0] gpio_out_in,
	input wire logic [15:0] mem_addr_in,
	output logic [31:0] gpio_dir,
	output logic [31:0] gpio_out,
	output logic [15:0] mem_addr,
	output logic crystal_drive_en,
	output logic pll_en,
	output logic booster_en,
	output logic usb_xcvr_en,
	output logic cpu_run,
	output logic cpu_wake_irq,
	output logic [15:0] fetch_addr,
	output logic fetch_valid,
	output logic host_port_irq_out,
	output logic irq
);
	import swr_pkg::*;

	swr_state_t state_reg;
	logic [15:0] pwr_reg;
	logic [15:0] usb_a_reg;
	logic [15:0] usb_b_reg;
	logic [ST_W-1:0] stat_reg;
	logic [ST_W-1:0] mask_reg;
	logic [31:0] gpio_dir_reg;
	logic [31:0] gpio_out_reg;
	logic [15:0] mem_addr_reg;
	logic role_prev_reg;
	logic pin24_prev_reg;
	logic pin25_prev_reg;
	logic boot_pending_reg;
	logic [1:0] fetch_step_reg;
	logic cpu_wake_irq_reg;
	logic settle_start;
	logic settle_busy;
	logic settle_done;
	logic usb_wake;
	logic other_wake;
	logic any_wake;
	logic resume_seen;
	logic wr_pwr;
	logic wr_stat;
	logic [ST_W-1:0] stat_set;
	logic [15:0] rd_mux;

	// Decode of register writes
	assign wr_pwr = bus.wr && (bus.addr == PWR_CTRL_ADDR);
	assign wr_stat = bus.wr && (bus.addr == IRQ_STAT_ADDR);

	// Wake qualification; bus power wakes on level, pins on either edge
	assign usb_wake = |(wake.usb_resume & pwr_reg[USB_WAKE_LO +: 4]);
	assign other_wake =
		(pwr_reg[OTG_WAKE_BIT] && (wake.otg_bus_power_pin ||
			(wake.otg_role_sense != role_prev_reg))) ||
		(pwr_reg[HPI_WAKE_BIT] && wake.host_parallel_port_rd) ||
		(pwr_reg[HSS_WAKE_BIT] && wake.fast_serial_link_rd) ||
		(pwr_reg[SPI_WAKE_BIT] && wake.spi_rd) ||
		(pwr_reg[GPI_WAKE_BIT] && ((wake.pin24_edge_wake != pin24_prev_reg) ||
			(wake.pin25_edge_wake != pin25_prev_reg)));
	assign any_wake = usb_wake || other_wake;
	assign resume_seen = |wake.usb_resume;

	// Settle counter starts on wake or on reset release
	assign settle_start = ((state_reg == SWR_SLEEP) && any_wake) || boot_pending_reg;

	swr_settle_timer #(
		.CYCLES(PLL_SETTLE_CYC)
	) u_settle (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(settle_start),
		.busy(settle_busy),
		.done(settle_done)
	);

	// One-cycle flag after reset release so settle wait follows every reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			boot_pending_reg <= 1'b1;
		else
			boot_pending_reg <= 1'b0;
	end

	// Sleep sequencer
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_reg <= SWR_SETTLE;
		else
		begin
			unique case (state_reg)
				SWR_RUN:
					if (wr_pwr && bus.wdata[SLEEP_BIT])
						state_reg <= SWR_SLEEP;
				SWR_SLEEP:
					if (any_wake)
						state_reg <= SWR_SETTLE;
				SWR_SETTLE:
					if (!settle_start && !settle_busy)
						state_reg <= SWR_RUN;
			endcase
		end
	end

	// Power control register; sleep bit self-clears on wake
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			pwr_reg <= PWR_RESET;
		else if (wr_pwr)
			pwr_reg <= bus.wdata & PWR_WR_MASK;
		else if ((state_reg == SWR_SLEEP) && any_wake)
			pwr_reg[SLEEP_BIT] <= 1'b0;
	end

	// Registers touched by a USB bus reset, and nothing else is
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || usb_bus_reset)
		begin
			usb_a_reg <= USB_REG_A_RESET;
			usb_b_reg <= USB_REG_B_RESET;
		end
		else if (bus.wr && (bus.addr == USB_REG_A_ADDR))
			usb_a_reg <= bus.wdata;
		else if (bus.wr && (bus.addr == USB_REG_B_ADDR))
			usb_b_reg <= bus.wdata;
	end

	// Edge history for the edge-sensitive wake inputs
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			role_prev_reg <= 1'b0;
			pin24_prev_reg <= 1'b0;
			pin25_prev_reg <= 1'b0;
		end
		else
		begin
			role_prev_reg <= wake.otg_role_sense;
			pin24_prev_reg <= wake.pin24_edge_wake;
			pin25_prev_reg <= wake.pin25_edge_wake;
		end
	end

	// Sticky status; set wins over a write-one clear
	assign stat_set[ST_WAKE] = (state_reg == SWR_SLEEP) && any_wake;
	assign stat_set[ST_RESUME] = resume_seen;
	assign stat_set[ST_READY] = settle_done;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stat_reg <= '0;
			mask_reg <= '0;
		end
		else
		begin
			stat_reg <= (stat_reg & ~(wr_stat ? bus.wdata[ST_W-1:0] : '0)) | stat_set;
			if (bus.wr && (bus.addr == IRQ_MASK_ADDR))
				mask_reg <= bus.wdata[ST_W-1:0];
		end
	end

	assign irq = |(stat_reg & mask_reg);
	assign host_port_irq_out = stat_reg[ST_RESUME];

	// CPU wake interrupt only for non-USB wake sources
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cpu_wake_irq_reg <= 1'b0;
		else if ((state_reg == SWR_SLEEP) && other_wake)
			cpu_wake_irq_reg <= 1'b1;
		else if (state_reg == SWR_RUN)
			cpu_wake_irq_reg <= 1'b0;
	end
	assign cpu_wake_irq = cpu_wake_irq_reg && (state_reg == SWR_RUN);

	// Pin parking: GPIO frozen, address bus pulled low while asleep
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			gpio_dir_reg <= '0;
			gpio_out_reg <= '0;
			mem_addr_reg <= '0;
		end
		else if (state_reg == SWR_SLEEP)
		begin
			mem_addr_reg <= '0;
		end
		else
		begin
			gpio_dir_reg <= gpio_dir_in;
			gpio_out_reg <= gpio_out_in;
			mem_addr_reg <= (wr_pwr && bus.wdata[SLEEP_BIT]) ? '0 : mem_addr_in;
		end
	end
	// Frozen copies keep GPIO pin state across sleep
	assign gpio_dir = gpio_dir_reg;
	assign gpio_out = gpio_out_reg;
	assign mem_addr = mem_addr_reg;

	// Clock and analog power enables
	assign crystal_drive_en = (state_reg != SWR_SLEEP);
	assign pll_en = (state_reg != SWR_SLEEP);
	assign booster_en = (state_reg != SWR_SLEEP);
	assign usb_xcvr_en = (state_reg != SWR_SLEEP);
	assign cpu_run = (state_reg == SWR_RUN);

	// Boot fetch: reset vector then jump target, once per reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			fetch_step_reg <= 2'h0;
		else if ((state_reg == SWR_RUN) && (fetch_step_reg != 2'h2))
			fetch_step_reg <= fetch_step_reg + 2'h1;
	end
	assign fetch_valid = (state_reg == SWR_RUN) && (fetch_step_reg != 2'h2);
	assign fetch_addr = (fetch_step_reg == 2'h0) ? RESET_VECTOR : BOOT_ROM_START;

	// Read mux, zero for unmapped addresses
	always_comb
	begin
		rd_mux = 16'h0000;
		unique case (bus.addr)
			PWR_CTRL_ADDR:
				rd_mux = (pwr_reg & PWR_WR_MASK) | (16'(boost_ok) << BOOST_OK_BIT);
			IRQ_STAT_ADDR:
				rd_mux = {13'h0000, stat_reg};
			IRQ_MASK_ADDR:
				rd_mux = {13'h0000, mask_reg};
			USB_REG_A_ADDR:
				rd_mux = usb_a_reg;
			USB_REG_B_ADDR:
				rd_mux = usb_b_reg;
			default:
				rd_mux = 16'h0000;
		endcase
	end

	// Read data stands the cycle after the strobe only
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rdata <= 16'h0000;
		else if (bus.rd)
			rdata <= rd_mux;
		else
			rdata <= 16'h0000;
	end
endmodule // swr_sleep_wake_ctrl

// ==== swr_pkg.sv ====
package swr_pkg;
	// Register offsets (byte addresses on the 16-bit register port)
	localparam logic [15:0] PWR_CTRL_ADDR = 16'hC00A;
	localparam logic [15:0] IRQ_STAT_ADDR = 16'hC0F0;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'hC0F2;
	localparam logic [15:0] USB_REG_A_ADDR = 16'hC090;
	localparam logic [15:0] USB_REG_B_ADDR = 16'hC0B0;
	// Power control field positions
	localparam int HALT_BIT = 0;
	localparam int SLEEP_BIT = 1;
	localparam int BOOST_OK_BIT = 2;
	localparam int GPI_WAKE_BIT = 4;
	localparam int HPI_WAKE_BIT = 7;
	localparam int SPI_WAKE_BIT = 8;
	localparam int HSS_WAKE_BIT = 9;
	localparam int OTG_WAKE_BIT = 11;
	localparam int USB_WAKE_LO = 12;
	// Writable bits of the power control register
	localparam logic [15:0] PWR_WR_MASK = 16'hFB93;
	localparam logic [15:0] PWR_RESET = 16'h0000;
	localparam logic [15:0] USB_REG_A_RESET = 16'h0000;
	localparam logic [15:0] USB_REG_B_RESET = 16'h0000;
	// Status bits: 0 wake seen, 1 usb resume, 2 settle done
	localparam int ST_WAKE = 0;
	localparam int ST_RESUME = 1;
	localparam int ST_READY = 2;
	localparam int ST_W = 3;
	// Boot vectors
	localparam logic [15:0] RESET_VECTOR = 16'hFF00;
	localparam logic [15:0] BOOT_ROM_START = 16'hE000;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int PLL_SETTLE_US = 200;
	localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
	localparam int CNT_W = 16;

	typedef enum {
		SWR_RUN,
		SWR_SLEEP,
		SWR_SETTLE
	} swr_state_t;

	// Wake event sources, already synchronous to ref_clk
	typedef struct packed {
		logic [3:0] usb_resume;
		logic otg_bus_power_pin;
		logic otg_role_sense;
		logic host_parallel_port_rd;
		logic fast_serial_link_rd;
		logic spi_rd;
		logic pin24_edge_wake;
		logic pin25_edge_wake;
	} swr_wake_t;

	// Register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} swr_bus_t;
endpackage

// ==== swr_settle_timer.sv ====
`timescale 1ns/100ps
module swr_settle_timer
	import swr_pkg::*;
#(
	parameter int CYCLES = 40000
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic start,
	output logic busy,
	output logic done
);
	import swr_pkg::*;
	logic [CNT_W-1:0] cnt_reg;

	// Down counter; reload on start, one-cycle done at zero
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cnt_reg <= '0;
			done <= 1'b0;
		end
		else if (start)
		begin
			cnt_reg <= CNT_W'(CYCLES);
			done <= 1'b0;
		end
		else if (cnt_reg != '0)
		begin
			cnt_reg <= cnt_reg - 1'b1;
			done <= (cnt_reg == CNT_W'(1));
		end
		else
			done <= 1'b0;
	end

	assign busy = (cnt_reg != '0);
endmodule // swr_settle_timer

// ==== swr_chk_assertions.sv ====
`timescale 1ns/100ps
module swr_chk
	import swr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire swr_pkg::swr_bus_t bus,
	input wire swr_pkg::swr_wake_t wake,
	input wire logic [31:0] gpio_dir,
	input wire logic [15:0] mem_addr,
	input wire logic crystal_drive_en,
	input wire logic pll_en,
	input wire logic booster_en,
	input wire logic usb_xcvr_en,
	input wire logic cpu_run,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_valid,
	input wire logic host_port_irq_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	int settle_cnt;
	// Settle length count; a counter since the wait is far past unroll limits
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !pll_en || cpu_run)
			settle_cnt <= 0;
		else
			settle_cnt <= settle_cnt + 1;
	end
	a_sleep_entry: assert property (cpu_run && bus.wr && bus.addr == PWR_CTRL_ADDR
		&& bus.wdata[SLEEP_BIT] |=> !pll_en && !cpu_run) else $error("sleep not entered");
	a_clocks_off: assert property (!pll_en |->
		!crystal_drive_en && !booster_en && !usb_xcvr_en) else $error("power left on");
	a_addr_low: assert property (!pll_en |-> mem_addr == 16'h0000)
		else $error("address not low");
	a_gpio_hold: assert property (!pll_en && !$past(pll_en) |-> $stable(gpio_dir))
		else $error("gpio moved");
	a_cpu_halt: assert property (!pll_en |-> !cpu_run) else $error("cpu ran");
	a_settle_hold: assert property ($rose(pll_en) |-> !cpu_run [*8])
		else $error("cpu ran early");
	a_settle_bound: assert property (settle_cnt <= PLL_SETTLE_CYC + 4)
		else $error("settle too long");
	a_boot_jump: assert property (fetch_valid && fetch_addr == RESET_VECTOR |=>
		fetch_valid && fetch_addr == BOOT_ROM_START) else $error("no boot jump");
	a_resume_irq: assert property (wake.usb_resume != 4'h0 |-> ##[1:3] host_port_irq_out)
		else $error("no host irq");
	cover property ($fell(pll_en));
	cover property ($rose(cpu_run));
	cover property ($rose(host_port_irq_out));
endmodule // swr_chk
bind swr_sleep_wake_ctrl swr_chk u_chk (.ref_clk, .sys_rst, .bus, .wake, .gpio_dir, .mem_addr,
	.crystal_drive_en, .pll_en, .booster_en, .usb_xcvr_en, .cpu_run, .fetch_addr,
	.fetch_valid, .host_port_irq_out);

// ==== swr_far_end.sv ====
`timescale 1ns/100ps
// Far side stand-in: link reads, resume signalling, pin edges
module swr_far_end
	import swr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [1:0] cmd,
	output swr_pkg::swr_wake_t wake
);
	// Bus power pin stays low: firmware has the charge pump off before sleep
	initial wake = '0;
	// Reads are one-cycle pulses; resume and pin 24 toggle as levels
	always @(posedge ref_clk)
	begin
		wake.spi_rd <= cmd == 2'h1;
		if (cmd == 2'h2)
			wake.usb_resume[0] <= !wake.usb_resume[0];
		if (cmd == 2'h3)
			wake.pin24_edge_wake <= !wake.pin24_edge_wake;
	end
endmodule // swr_far_end

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import swr_pkg::*;
	logic ref_clk, sys_rst, usb_bus_reset, boost_ok;
	swr_bus_t bus;
	swr_wake_t wake;
	logic [15:0] rdata, mem_addr, fetch_addr, mem_addr_in;
	logic [31:0] gpio_dir_in, gpio_out_in, gpio_dir, gpio_out;
	logic crystal_drive_en, pll_en, booster_en, usb_xcvr_en, cpu_run, cpu_wake_irq;
	logic fetch_valid, host_port_irq_out, irq;
	logic [1:0] cmd;
	int mismatches, samples_checked, seed, n;
	int mdl[int];
	logic [15:0] addrs[6] = '{PWR_CTRL_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR,
		USB_REG_A_ADDR, USB_REG_B_ADDR, 16'hC0FE};
	swr_sleep_wake_ctrl uut (.ref_clk, .sys_rst, .bus, .rdata, .wake, .usb_bus_reset,
		.boost_ok, .gpio_dir_in, .gpio_out_in, .mem_addr_in, .gpio_dir, .gpio_out, .mem_addr,
		.crystal_drive_en, .pll_en, .booster_en, .usb_xcvr_en, .cpu_run, .cpu_wake_irq,
		.fetch_addr, .fetch_valid, .host_port_irq_out, .irq);
	swr_far_end u_far (.ref_clk, .cmd, .wake);
	initial
	begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Register model: masked power bits, write-one-clear status
	task wr(input logic [15:0] a, d);
		@(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus <= '0;
		if (a == PWR_CTRL_ADDR)
			mdl[a] = d & PWR_WR_MASK;
		else if (a == IRQ_STAT_ADDR)
			mdl[a] = mdl[a] & ~d;
		else if (a == IRQ_MASK_ADDR)
			mdl[a] = d & 16'h0007;
		else if (a != 16'hC0FE)
			mdl[a] = d;
	endtask
	task rd(input logic [15:0] a);
		logic [15:0] e;
		e = 16'(mdl[a]);
		if (a == PWR_CTRL_ADDR)
			e[BOOST_OK_BIT] = boost_ok;
		@(posedge ref_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge ref_clk) bus <= '0;
		#1 chk("rdata", e, rdata);
	endtask
	task pulse(input logic [1:0] c);
		@(posedge ref_clk) cmd <= c;
		@(posedge ref_clk) cmd <= 2'h0;
	endtask
	// Bounded wait, so a stuck settle ends as a mismatch, not a hang
	task wait_run;
		n = 0;
		while (cpu_run !== 1'b1 && n < 41000)
		begin
			@(posedge ref_clk) #1 n++;
		end
		chk("settle", 1, n < 41000);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#450000 mismatches++;
		end_of_test;
	end
	initial
	begin
		seed = 57742;
		sys_rst = 1;
		bus = '0;
		cmd = 0;
		usb_bus_reset = 0;
		boost_ok = 1;
		gpio_dir_in = 32'h0F0F00FF;
		gpio_out_in = 32'hA5A55A5A;
		mem_addr_in = 16'h1234;
		foreach (addrs[i]) mdl[addrs[i]] = 0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 0;
		foreach (addrs[i]) rd(addrs[i]);
		foreach (addrs[i]) wr(addrs[i], 16'($random(seed) & 16'hFFFC));
		foreach (addrs[i]) rd(addrs[i]);
		@(posedge ref_clk) usb_bus_reset <= 1;
		@(posedge ref_clk) usb_bus_reset <= 0;
		mdl[USB_REG_A_ADDR] = 0;
		mdl[USB_REG_B_ADDR] = 0;
		foreach (addrs[i]) rd(addrs[i]);
		wait_run();
		chk("fetch", RESET_VECTOR, fetch_addr);
		@(posedge ref_clk) #1 chk("fetch", BOOT_ROM_START, fetch_addr);
		mdl[IRQ_STAT_ADDR] = 4;
		rd(IRQ_STAT_ADDR);
		wr(IRQ_STAT_ADDR, 16'h0007);
		wr(IRQ_MASK_ADDR, 16'h0007);
		wr(PWR_CTRL_ADDR, 16'h0012);
		#1 chk("pll_en", 0, pll_en);
		chk("booster_en", 0, booster_en);
		chk("mem_addr", 0, mem_addr);
		@(posedge ref_clk) gpio_dir_in <= 32'hF0F0FF00;
		pulse(1);
		pulse(2);
		repeat (4) @(posedge ref_clk);
		#1 chk("pll_en", 0, pll_en);
		chk("gpio_dir", 32'h0F0F00FF, gpio_dir);
		chk("host_irq", 1, host_port_irq_out);
		pulse(2);
		pulse(3);
		repeat (4) @(posedge ref_clk);
		#1 chk("pll_en", 1, pll_en);
		chk("cpu_run", 0, cpu_run);
		wait_run();
		chk("cpu_wake_irq", 1, cpu_wake_irq);
		mdl[IRQ_STAT_ADDR] = 7;
		mdl[PWR_CTRL_ADDR] = 16'h0010;
		rd(IRQ_STAT_ADDR);
		rd(PWR_CTRL_ADDR);
		chk("irq", 1, irq);
		wr(IRQ_STAT_ADDR, 16'h0007);
		#1 chk("irq", 0, irq);
		end_of_test;
	end
endmodule // tb
